// File: design/dpll_mode_pkg.sv
// shared constants and types for the loop mode selector
package dpll_mode_pkg;

  // ----------------------------------------------------------
  // channel count and field sizes
  // ----------------------------------------------------------
  localparam int NCH = 2;             // loop channels
  localparam int PRI_W = 5;           // priority width
  localparam int IDX_W = 14;          // register index width
  localparam logic [5:0] REVERT_GAP = 6'h08; // revert margin

  // ----------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CLR0 = 14'h200c;
  localparam logic [IDX_W-1:0] IDX_CLR1 = 14'h2011;
  localparam logic [IDX_W-1:0] IDX_MODE0 = 14'h2105;
  localparam logic [IDX_W-1:0] IDX_MODE1 = 14'h2205;
  localparam logic [IDX_W-1:0] IDX_ACT0 = 14'h3009;
  localparam logic [IDX_W-1:0] IDX_ACT1 = 14'h300a;
  localparam logic [IDX_W-1:0] IDX_EVT0 = 14'h3011;
  localparam logic [IDX_W-1:0] IDX_EVT1 = 14'h3016;
  localparam logic [IDX_W-1:0] IDX_PRI0 = 14'h2110;
  localparam logic [IDX_W-1:0] IDX_PRI1 = 14'h2210;
  localparam logic [IDX_W-1:0] IDX_FRW0 = 14'h2120;
  localparam logic [IDX_W-1:0] IDX_FRW1 = 14'h2220;

  // ----------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------
  localparam int EVT_LSB = 5;         // event bits 7:5
  localparam logic [7:0] MODE_RST = 8'h00;   // auto, no force
  localparam logic [4:0] PRI_RST = 5'h1f;    // least favoured
  localparam logic [31:0] FRW_RST = 32'h0000_0000;

  // selection mode field codes
  localparam logic [1:0] SEL_AUTO = 2'h0;
  localparam logic [1:0] SEL_MAN_PRI = 2'h1;
  localparam logic [1:0] SEL_MAN_HOLD = 2'h2;
  localparam logic [1:0] SEL_MAN_ONLY = 2'h3;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {LOOP_CLOSED, LOOP_HOLD, LOOP_FREE} loop_state_t;

  // mode control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic spare;
    logic [2:0] manual_profile_index;
    logic [1:0] sel_mode;
    logic force_hold_control;
    logic force_open_loop_control;
  } mode_reg_t;

  // per-channel result seen by the loop datapath
  typedef struct packed {
    loop_state_t state;
    logic [2:0] profile;
    logic [5:0] active;
    logic switching;
    logic [1:0] hold_word_sel;
    logic [31:0] open_loop_frequency_word;
  } ch_status_t;

endpackage

// File: design/dpll_reference_mode_selector.sv
// loop mode and reference profile selector for two loop channels
`timescale 1ns/1ps

module dpll_reference_mode_selector
  import dpll_mode_pkg::*;
#(
  parameter int N_PROF = 6 // profiles per channel
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write when high
  input wire logic [15:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire logic [NCH-1:0][N_PROF-1:0] prof_valid, // profile validity
  input wire logic [NCH-1:0] hist_avail, // history ready
  input wire logic [NCH-1:0][1:0] hist_word, // history word pick
  output ch_status_t [NCH-1:0] loop_status // per-channel result
);

  // ----------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------
  // the active field only holds six profiles; the index field holds eight
  if (N_PROF < 1 || N_PROF > 6) begin : g_bad_prof
    $error("N_PROF must be 1 to 6");
  end

  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  typedef logic [N_PROF-1:0][PRI_W-1:0] pri_vec_t;

  mode_reg_t mode_reg [NCH]; // mode control per channel
  pri_vec_t pri [NCH]; // profile priorities
  logic [31:0] frw [NCH]; // freerun tuning words
  loop_state_t state [NCH]; // present loop state
  loop_state_t next_state [NCH]; // decided loop state
  logic [2:0] cur [NCH]; // profile in use
  logic [2:0] next_cur [NCH]; // decided profile
  logic [2:0] prev [NCH]; // switched-from profile
  logic prev_on [NCH]; // prev holds a real profile
  logic [2:0] evt [NCH]; // switch, freerun, holdover
  logic [2:0] evt_set [NCH]; // this cycle's events
  logic [2:0] evt_clr [NCH]; // software clear pulse
  logic [5:0] act [NCH]; // active profile bits
  logic sw_pulse [NCH]; // switching marker
  logic [1:0] hw_sel [NCH]; // held history word pick
  logic [IDX_W-1:0] idx; // word index of access
  logic req; // request waiting for ack
  logic wr_en; // write takes effect now
  logic [31:0] rd_mux; // read data before register

  // ----------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------
  // profile index usable and valid
  function automatic logic prof_ok(input logic [N_PROF-1:0] v,
                                   input logic [2:0] p);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N_PROF; i++) begin
      if (p == 3'(i)) begin
        r = v[i];
      end
    end
    return r;
  endfunction

  // priority of one profile
  function automatic logic [PRI_W-1:0] pri_of(input pri_vec_t pv,
                                               input logic [2:0] p);
    logic [PRI_W-1:0] r;
    r = '1;
    for (int i = 0; i < N_PROF; i++) begin
      if (p == 3'(i)) begin
        r = pv[i];
      end
    end
    return r;
  endfunction

  // search: lowest value wins, ties go to the lower index;
  // result is {found, index}
  function automatic logic [3:0] pick(input logic [N_PROF-1:0] v,
                                      input pri_vec_t pv);
    logic found;
    logic [2:0] best;
    logic [PRI_W-1:0] bp;
    found = 1'b0;
    best = 3'h0;
    bp = '1;
    for (int i = 0; i < N_PROF; i++) begin
      if (v[i] && (!found || pv[i] < bp)) begin
        found = 1'b1;
        best = 3'(i);
        bp = pv[i];
      end
    end
    return {found, best};
  endfunction

  // ----------------------------------------------------------
  // mode decision, evaluated fresh every cycle
  // ----------------------------------------------------------
  // no state here: validity and control changes act at once
  always_comb begin
    mode_reg_t m;
    logic [3:0] pk;
    logic man_ok;
    logic rev;
    loop_state_t fall_st;
    loop_state_t auto_st;
    logic [2:0] auto_cur;
    m = '0;
    pk = 4'h0;
    man_ok = 1'b0;
    rev = 1'b0;
    fall_st = LOOP_HOLD;
    auto_st = LOOP_HOLD;
    auto_cur = 3'h0;
    for (int c = 0; c < NCH; c++) begin
      m = mode_reg[c];
      pk = pick(prof_valid[c], pri[c]);
      // manual index must name a real and valid profile
      man_ok = prof_ok(prof_valid[c], m.manual_profile_index);
      // open-loop fallback: freerun when no history exists
      fall_st = hist_avail[c] ? LOOP_HOLD : LOOP_FREE;
      // revert when the old profile is at least 8 better
      rev = prev_on[c] && prof_ok(prof_valid[c], prev[c]) &&
            ({1'b0, pri_of(pri[c], cur[c])} >=
             {1'b0, pri_of(pri[c], prev[c])} + REVERT_GAP);
      // automatic priority selection
      if (state[c] == LOOP_CLOSED && prof_ok(prof_valid[c], cur[c])) begin
        auto_st = LOOP_CLOSED;
        auto_cur = rev ? prev[c] : cur[c];
      end else if (pk[3]) begin
        auto_st = LOOP_CLOSED;
        auto_cur = pk[2:0];
      end else begin
        auto_st = fall_st;
        auto_cur = cur[c];
      end
      next_state[c] = auto_st;
      next_cur[c] = auto_cur;
      if (m.force_open_loop_control) begin
        next_state[c] = LOOP_FREE;
        next_cur[c] = cur[c];
      end else if (m.force_hold_control) begin
        next_state[c] = LOOP_HOLD;
        next_cur[c] = cur[c];
      end else begin
        case (m.sel_mode)
          SEL_AUTO: begin
            next_state[c] = auto_st;
            next_cur[c] = auto_cur;
          end
          SEL_MAN_PRI: begin
            if (man_ok) begin
              next_state[c] = LOOP_CLOSED;
              next_cur[c] = m.manual_profile_index;
            end
          end
          SEL_MAN_HOLD: begin
            if (man_ok) begin
              next_state[c] = LOOP_CLOSED;
              next_cur[c] = m.manual_profile_index;
            end else begin
              next_state[c] = fall_st;
              next_cur[c] = cur[c];
            end
          end
          SEL_MAN_ONLY: begin
            // no fallback search; only an out-of-range index opens
            if (m.manual_profile_index < 3'(N_PROF)) begin
              next_state[c] = LOOP_CLOSED;
              next_cur[c] = m.manual_profile_index;
            end else begin
              next_state[c] = fall_st;
              next_cur[c] = cur[c];
            end
          end
          default: begin
            next_state[c] = fall_st;
            next_cur[c] = cur[c];
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // event detection
  // ----------------------------------------------------------
  // events are edges of the decision, so a steady state sets nothing
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      evt_set[c][2] = next_state[c] == LOOP_CLOSED &&
                      (state[c] != LOOP_CLOSED || next_cur[c] != cur[c]);
      evt_set[c][1] = next_state[c] == LOOP_FREE &&
                      state[c] != LOOP_FREE;
      evt_set[c][0] = next_state[c] == LOOP_HOLD &&
                      state[c] != LOOP_HOLD;
    end
  end

  // ----------------------------------------------------------
  // loop state registers
  // ----------------------------------------------------------
  // starts in holdover so that the first lock raises a switch event
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) begin
        state[c] <= LOOP_HOLD;
        cur[c] <= 3'h0;
        prev[c] <= 3'h0;
        prev_on[c] <= 1'b0;
      end
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        state[c] <= next_state[c];
        cur[c] <= next_cur[c];
        // remember the profile we leave, for the revert test
        if (state[c] == LOOP_CLOSED &&
            (next_state[c] != LOOP_CLOSED || next_cur[c] != cur[c])) begin
          prev[c] <= cur[c];
          prev_on[c] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // status outputs: active bits, switch marker, word pick
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) begin
        act[c] <= 6'h00;
        sw_pulse[c] <= 1'b0;
        hw_sel[c] <= 2'h0;
      end
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        act[c] <= 6'h00;
        if (next_state[c] == LOOP_CLOSED) begin
          act[c] <= 6'h01 << next_cur[c];
        end
        sw_pulse[c] <= evt_set[c][2];
        // history pick follows in holdover and is frozen otherwise
        if (next_state[c] == LOOP_HOLD) begin
          hw_sel[c] <= hist_word[c];
        end
      end
    end
  end

  // ----------------------------------------------------------
  // latched event flags
  // ----------------------------------------------------------
  // an event in the clear cycle survives: set is applied last
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) begin
        evt[c] <= 3'h0;
      end
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        evt[c] <= (evt[c] & ~evt_clr[c]) | evt_set[c];
      end
    end
  end

  // ----------------------------------------------------------
  // output bundle
  // ----------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      loop_status[c].state = state[c];
      loop_status[c].profile = cur[c];
      loop_status[c].active = act[c];
      loop_status[c].switching = sw_pulse[c];
      loop_status[c].hold_word_sel = hw_sel[c];
      loop_status[c].open_loop_frequency_word = frw[c];
    end
  end

  // ----------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------
  // one wait cycle: ack follows the request edge, then drops
  assign idx = wb_adr_i[15:2];
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && wb_ack_o;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  // ----------------------------------------------------------
  // clear pulses
  // ----------------------------------------------------------
  // writing one to bits 7:5 clears; zeros leave flags alone
  always_comb begin
    evt_clr[0] = 3'h0;
    evt_clr[1] = 3'h0;
    if (wr_en && wb_sel_i[0]) begin
      if (idx == IDX_CLR0) begin
        evt_clr[0] = wb_dat_i[EVT_LSB+2:EVT_LSB];
      end
      if (idx == IDX_CLR1) begin
        evt_clr[1] = wb_dat_i[EVT_LSB+2:EVT_LSB];
      end
    end
  end

  // ----------------------------------------------------------
  // mode control registers
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg[0] <= mode_reg_t'(MODE_RST);
      mode_reg[1] <= mode_reg_t'(MODE_RST);
    end else if (ce && wr_en && wb_sel_i[0]) begin
      if (idx == IDX_MODE0) begin
        mode_reg[0] <= mode_reg_t'(wb_dat_i[7:0]);
      end
      if (idx == IDX_MODE1) begin
        mode_reg[1] <= mode_reg_t'(wb_dat_i[7:0]);
      end
    end
  end

  // ----------------------------------------------------------
  // priority registers, one word per profile
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) begin
        for (int p = 0; p < N_PROF; p++) begin
          pri[c][p] <= PRI_RST;
        end
      end
    end else if (ce && wr_en && wb_sel_i[0]) begin
      for (int p = 0; p < N_PROF; p++) begin
        if (idx == IDX_PRI0 + IDX_W'(p)) begin
          pri[0][p] <= wb_dat_i[PRI_W-1:0];
        end
        if (idx == IDX_PRI1 + IDX_W'(p)) begin
          pri[1][p] <= wb_dat_i[PRI_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------
  // freerun tuning words, byte-lane writable
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frw[0] <= FRW_RST;
      frw[1] <= FRW_RST;
    end else if (ce && wr_en) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && idx == IDX_FRW0) begin
          frw[0][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
        if (wb_sel_i[b] && idx == IDX_FRW1) begin
          frw[1][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------
  // read mux; clear registers and unmapped words read zero
  // ----------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (idx == IDX_MODE0) begin
      rd_mux[7:0] = mode_reg[0];
    end else if (idx == IDX_MODE1) begin
      rd_mux[7:0] = mode_reg[1];
    end else if (idx == IDX_EVT0) begin
      rd_mux[EVT_LSB+2:EVT_LSB] = evt[0];
    end else if (idx == IDX_EVT1) begin
      rd_mux[EVT_LSB+2:EVT_LSB] = evt[1];
    end else if (idx == IDX_ACT0) begin
      rd_mux[5:0] = act[0];
    end else if (idx == IDX_ACT1) begin
      rd_mux[5:0] = act[1];
    end else if (idx == IDX_FRW0) begin
      rd_mux = frw[0];
    end else if (idx == IDX_FRW1) begin
      rd_mux = frw[1];
    end
    for (int p = 0; p < N_PROF; p++) begin
      if (idx == IDX_PRI0 + IDX_W'(p)) begin
        rd_mux[PRI_W-1:0] = pri[0][p];
      end
      if (idx == IDX_PRI1 + IDX_W'(p)) begin
        rd_mux[PRI_W-1:0] = pri[1][p];
      end
    end
  end

  // read data is captured with ack so it stands during ack
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && req && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

endmodule // dpll_reference_mode_selector

// File: tb/dpll_mode_checker_assertions.sv
// port-level assertion checker for the loop mode selector
`timescale 1ns/1ps

module dpll_mode_checker
  import dpll_mode_pkg::*;
#(
  parameter int N_PROF = 6 // profiles per channel
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write when high
  input wire logic [15:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // bus acknowledge
  input wire logic [NCH-1:0][N_PROF-1:0] prof_valid, // profile validity
  input wire logic [NCH-1:0] hist_avail, // history ready
  input wire logic [NCH-1:0][1:0] hist_word, // history word pick
  input wire ch_status_t [NCH-1:0] loop_status // per-channel result
);
  // ----------------------------------------------------------
  // shadow of channel 0 force bits, taken at the write's ack edge
  // ----------------------------------------------------------
  logic [1:0] frc; // bit0 force freerun, bit1 force holdover

  // the mode register is hidden, so follow accepted bus writes to it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frc <= 2'h0;
    end else if (ce && wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                 && wb_adr_i[15:2] == IDX_MODE0) begin
      frc <= wb_dat_i[1:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  chk_ack_answer: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  chk_ack_pulse: assert property (ce && wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  chk_switch_pulse: assert property (
    loop_status[0].state == LOOP_CLOSED && ($past(loop_status[0].state) != LOOP_CLOSED
    || $past(loop_status[0].profile) != loop_status[0].profile) |-> loop_status[0].switching)
    else $error("move to a profile without switching pulse");
  chk_active_onehot: assert property (
    loop_status[0].state == LOOP_CLOSED |->
    loop_status[0].active == 6'h01 << loop_status[0].profile)
    else $error("active bits do not match current profile");
  chk_no_valid_open: assert property (ce && prof_valid[1] == '0 ##1 ce |->
    loop_status[1].state != LOOP_CLOSED)
    else $error("closed loop with no valid profile");
  chk_hold_word: assert property (
    $past(rstn) && $past(ce) && loop_status[0].state == LOOP_HOLD
    |-> loop_status[0].hold_word_sel == $past(hist_word[0]))
    else $error("holdover word not taken from history pick");
  chk_force_free: assert property (ce && frc[0] ##1 ce |->
    loop_status[0].state == LOOP_FREE)
    else $error("forced freerun not obeyed");
  chk_force_hold: assert property (ce && frc == 2'h2 ##1 ce |->
    loop_status[0].state == LOOP_HOLD)
    else $error("forced holdover not obeyed");
endmodule // dpll_mode_checker

bind dpll_reference_mode_selector dpll_mode_checker #(.N_PROF(N_PROF)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prof_valid(prof_valid), .hist_avail(hist_avail),
  .hist_word(hist_word), .loop_status(loop_status));

// File: tb/tb_top.sv
// self-checking testbench for the loop mode selector
`timescale 1ns/1ps

module tb_top
  import dpll_mode_pkg::*;
;
  logic sys_clk = 1'b0; // 10 MHz
  logic rstn = 1'b0; // held low 20 cycles
  logic ce = 1'b1; // clock enable, dropped low only in t_freeze
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0; // bus request
  logic [15:0] wb_adr_i = 16'h0000; // byte address
  logic [3:0] wb_sel_i = 4'h0; // byte lanes
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q; // data and last read
  logic wb_ack_o; // answer
  logic [NCH-1:0][5:0] prof_valid = {6'h00, 6'h3f}; // ch1 starts with nothing valid
  logic [NCH-1:0] hist_avail = 2'b01; // ch1 falls back to freerun
  logic [NCH-1:0][1:0] hist_word = 4'h1; // history picks
  ch_status_t [NCH-1:0] loop_status; // results
  int n_mismatch = 0, check_count = 0, cyc_count = 0;

  dpll_reference_mode_selector #(.N_PROF(6)) dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .prof_valid(prof_valid), .hist_avail(hist_avail), .hist_word(hist_word),
    .loop_status(loop_status));

  // ----------------------------------------------------------
  // clock, hang guard and shared tasks
  // ----------------------------------------------------------
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    // no wait limit here: only the bench's cycle ceiling ends a hang
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // ack comes the cycle after the request is seen
    check_val("ack wait", 32'h2, 32'(n));
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    wb_xfer(1'b1, idx, d);
  endtask

  task automatic rd_chk(input string what, input logic [13:0] idx, input logic [31:0] exp);
    wb_xfer(1'b0, idx, 32'h0);
    check_val(what, exp, q);
  endtask

  // let the decision edge pass, then look at settled outputs
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic set_valid(input int ch, input logic [5:0] v);
    @(posedge sys_clk);
    prof_valid[ch] <= v;
    settle();
  endtask

  // profile is only meaningful while the loop is closed
  task automatic st_chk(input int ch, input loop_state_t s, input logic [2:0] p);
    // look away from the launching edge, where outputs still move
    @(negedge sys_clk);
    check_val("loop state", 32'(s), 32'(loop_status[ch].state));
    if (s == LOOP_CLOSED) check_val("profile", 32'(p), 32'(loop_status[ch].profile));
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset_regs();
    rd_chk("mode0", IDX_MODE0, 32'(MODE_RST));
    rd_chk("prio0", IDX_PRI0, 32'(PRI_RST));
    rd_chk("unmapped", 14'h0123, 32'h0);
    rd_chk("events0", IDX_EVT0, 32'h80);
    rd_chk("events1", IDX_EVT1, 32'h40);
    rd_chk("active0", IDX_ACT0, 32'h01);
    st_chk(0, LOOP_CLOSED, 3'h0);
    st_chk(1, LOOP_FREE, 3'h0);
    wr(IDX_EVT0, 32'hff);
    rd_chk("events0", IDX_EVT0, 32'h80);
    wr(IDX_CLR0, 32'he0);
    wr(IDX_CLR1, 32'he0);
    rd_chk("events0", IDX_EVT0, 32'h0);
    rd_chk("clear0", IDX_CLR0, 32'h0);
  endtask

  // priorities 3 and 12, then 3 and 10, straddle the revert margin
  task automatic t_priority();
    wr(IDX_PRI0 + 14'h2, 32'h03);
    wr(IDX_PRI0 + 14'h4, 32'h0c);
    set_valid(0, 6'h3e);
    st_chk(0, LOOP_CLOSED, 3'h2);
    rd_chk("events0", IDX_EVT0, 32'h80);
    set_valid(0, 6'h3a);
    st_chk(0, LOOP_CLOSED, 3'h4);
    set_valid(0, 6'h3e);
    st_chk(0, LOOP_CLOSED, 3'h2);
    wr(IDX_PRI0 + 14'h4, 32'h0a);
    set_valid(0, 6'h3a);
    set_valid(0, 6'h3e);
    st_chk(0, LOOP_CLOSED, 3'h4);
    wr(IDX_CLR0, 32'he0);
  endtask

  task automatic t_force();
    wr(IDX_FRW0, 32'h1234_5678);
    @(posedge sys_clk);
    hist_word[0] <= 2'h2;
    settle();
    check_val("freerun word", 32'h1234_5678, loop_status[0].open_loop_frequency_word);
    wr(IDX_MODE0, 32'h02);
    settle();
    st_chk(0, LOOP_HOLD, 3'h0);
    check_val("hold word", 32'h2, 32'(loop_status[0].hold_word_sel));
    wr(IDX_MODE0, 32'h03);
    settle();
    st_chk(0, LOOP_FREE, 3'h0);
    rd_chk("events0", IDX_EVT0, 32'h60);
    wr(IDX_MODE0, 32'h00);
    settle();
    check_val("loop state", 32'(LOOP_CLOSED), 32'(loop_status[0].state));
    rd_chk("events0", IDX_EVT0, 32'he0);
    wr(IDX_CLR0, 32'he0);
  endtask

  task automatic t_modes();
    wr(IDX_MODE0, 32'h54);
    settle();
    st_chk(0, LOOP_CLOSED, 3'h5);
    rd_chk("mode0", IDX_MODE0, 32'h54);
    set_valid(0, 6'h1e);
    st_chk(0, LOOP_CLOSED, 3'h2);
    wr(IDX_MODE0, 32'h58);
    settle();
    st_chk(0, LOOP_HOLD, 3'h0);
    @(posedge sys_clk);
    hist_avail[0] <= 1'b0;
    settle();
    st_chk(0, LOOP_FREE, 3'h0);
    wr(IDX_MODE0, 32'h1c);
    settle();
    st_chk(0, LOOP_CLOSED, 3'h1);
    wr(IDX_MODE0, 32'h00);
    wr(IDX_MODE1, 32'h02);
    settle();
    st_chk(1, LOOP_HOLD, 3'h0);
    wr(IDX_MODE1, 32'h00);
    set_valid(1, 6'h08);
    st_chk(1, LOOP_CLOSED, 3'h3);
    rd_chk("events1", IDX_EVT1, 32'he0);
  endtask

  // ce low holds the last decision; the pending one lands on release
  task automatic t_freeze();
    @(posedge sys_clk);
    ce <= 1'b0;
    prof_valid[1] <= 6'h00;
    settle();
    st_chk(1, LOOP_CLOSED, 3'h3);
    @(posedge sys_clk);
    ce <= 1'b1;
    settle();
    st_chk(1, LOOP_FREE, 3'h0);
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    settle();
    t_reset_regs();
    t_priority();
    t_force();
    t_modes();
    t_freeze();
    give_verdict();
  end
endmodule // tb_top
